// ===== rtl/adcsr_conv.sv
`timescale 1ns/1ps
`include "adcsr_cfg.svh"

module adcsr_conv
  import adcsr_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire adcsr_res_t adc_core_data,
  adcsr_if.conv           bus
);

  adcsr_conv_st_t st_r;
  adcsr_conv_st_t st_nxt;
  adcsr_acc_t     sum;
  adcsr_res_t     avg;
  logic [2:0]     osr_eff;

  // ----------------------------------------
  // Averaging filter
  // ----------------------------------------
  assign osr_eff = (st_r.oversample_ratio > `ADCSR_OSR_MAX) ? 3'h0 : st_r.oversample_ratio;

  for (genvar c = 0; c < `ADCSR_NUM_CH; c++) begin : g_ch
    assign sum[c] = st_r.acc[c] + {6'h00, adc_core_data[c]};
    assign avg[c] = 16'(sum[c] >> osr_eff);
  end

  // ----------------------------------------
  // Conversion sequencing
  // ----------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.load  = 1'b0;
    st_nxt.sta_d = bus.start_a;
    st_nxt.stb_d = bus.start_b;
    if (!st_r.busy) begin
      if (bus.start_a && !st_r.sta_d) st_nxt.arm_a = 1'b1;
      if (bus.start_b && !st_r.stb_d) st_nxt.arm_b = 1'b1;
      if (st_nxt.arm_a && st_nxt.arm_b) begin
        st_nxt.busy  = 1'b1;
        st_nxt.arm_a = 1'b0;
        st_nxt.arm_b = 1'b0;
        st_nxt.step  = 8'h00;
        st_nxt.samp  = 7'h00;
        st_nxt.acc   = '0;
      end
    end else if (st_r.step == 8'(`ADCSR_CONV_CYC - 1)) begin
      st_nxt.step = 8'h00;
      st_nxt.acc  = sum;
      if (st_r.samp == (7'h01 << osr_eff) - 7'h01) begin
        st_nxt.busy = 1'b0;
        st_nxt.load = 1'b1;
        st_nxt.res  = avg;
        st_nxt.oversample_ratio  = bus.os_sel;
      end else begin
        st_nxt.samp = st_r.samp + 7'h01;
      end
    end else begin
      st_nxt.step = st_r.step + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.busy = st_r.busy;
  assign bus.load = st_r.load;
  assign bus.res  = st_r.res;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [13:0] bcnt;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bcnt <= 14'h0000;
    end else begin
      bcnt <= st_r.busy ? bcnt + 14'h0001 : 14'h0000;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  start_pair_a: assert property ($rose(st_r.busy) |->
      $past(st_r.arm_a || bus.start_a) && $past(st_r.arm_b || bus.start_b))
    else $error("busy without both start edges");
  res_hold_a: assert property ($changed(st_r.res) |-> st_r.load && $fell(st_r.busy))
    else $error("results changed outside busy fall");
  osr_latch_a: assert property ($changed(st_r.oversample_ratio) |-> $fell(st_r.busy))
    else $error("ratio latched outside busy fall");
  busy_len_a: assert property ($fell(st_r.busy) |->
      bcnt == (14'(`ADCSR_CONV_CYC) << $past(osr_eff)))
    else $error("busy length does not match ratio");
  no_filter_a: assert property (st_r.load && $past(osr_eff) == 3'h0 |->
      st_r.res == $past(adc_core_data))
    else $error("unfiltered result mismatch");

  cov_osr64_c: cover property ($fell(st_r.busy) && $past(osr_eff) == 3'h6);
  cov_osr1_c:  cover property ($fell(st_r.busy) && $past(osr_eff) == 3'h0);

endmodule : adcsr_conv

// ===== rtl/adcsr_top.sv
`timescale 1ns/1ps
`include "adcsr_cfg.svh"

// Operation
// - Sixteen clocks move one channel word
// - Channels follow in ascending order
// - First line: channels one-four then five-eight
// - Second line: five-eight then one-four
// - Marker high impedance while select high
// - Marker high for first sixteen clocks
// - Marker also flags channel five, second line
// - Both lines: 64 clocks suffice
// - Read while busy returns previous results
// - Reads never disturb conversion
// - Results loaded at busy fall
// - Ratio pins latched at busy fall
// - Busy time grows with ratio codes up to six
// - Ratio codes one to six average samples
// - Read after busy gives new results
// - Busy rises after both start edges
module adcsr_top
  import adcsr_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       cs_n_pin,
  input  wire logic       sclk_pin,
  input  wire logic       interface_select_pin,
  input  wire logic       byte_select_pin,
  input  wire logic [2:0] oversample_ratio_pins,
  input  wire logic       start_group_one,
  input  wire logic       start_group_two,
  input  wire adcsr_res_t adc_core_data,
  output logic            serial_out_first,
  output logic            serial_out_first_oe,
  output logic            serial_out_second,
  output logic            serial_out_second_oe,
  output logic            first_channel_marker,
  output logic            first_channel_marker_oe,
  output logic            busy
);

  adcsr_top_st_t st_r;
  adcsr_top_st_t st_nxt;
  adcsr_if       bus ();
  logic [8:0]    pins;
  logic [8:0]    agree;
  logic          ser_mode;
  logic          cs_act;
  logic          sclk_fall;
  logic [2:0]    word_a;
  logic [2:0]    word_b;
  logic [3:0]    bit_sel;

  // ----------------------------------------
  // Conversion core
  // ----------------------------------------
  adcsr_conv u_conv (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .adc_core_data (adc_core_data),
    .bus           (bus)
  );

  assign bus.start_a = st_r.stab[`ADCSR_P_STA];
  assign bus.start_b = st_r.stab[`ADCSR_P_STB];
  assign bus.os_sel  = st_r.stab[`ADCSR_P_OS +: 3];

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  assign pins = {oversample_ratio_pins, byte_select_pin, interface_select_pin,
                 start_group_two, start_group_one, sclk_pin, cs_n_pin};
  assign agree = ~(st_r.s2 ^ st_r.s3);

  // ----------------------------------------
  // Serial readout
  // ----------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = pins;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.stab = (st_r.s3 & agree) | (st_r.stab & ~agree);
    ser_mode  = st_nxt.stab[`ADCSR_P_IFS] && !st_nxt.stab[`ADCSR_P_BYS];
    cs_act    = ser_mode && !st_nxt.stab[`ADCSR_P_CS];
    sclk_fall = st_r.stab[`ADCSR_P_SCLK] && !st_nxt.stab[`ADCSR_P_SCLK];
    if (bus.load) begin
      st_nxt.bit_cnt = 7'h00;
    end else if (cs_act && sclk_fall) begin
      st_nxt.bit_cnt = st_r.bit_cnt + 7'h01;
    end
    word_a  = st_nxt.bit_cnt[6:4];
    word_b  = 3'(word_a + 3'h4);
    bit_sel = ~st_nxt.bit_cnt[3:0];
    st_nxt.dout_a  = bus.res[word_a][bit_sel];
    st_nxt.dout_b  = bus.res[word_b][bit_sel];
    st_nxt.oe_a    = cs_act;
    st_nxt.oe_b    = cs_act;
    st_nxt.mark    = cs_act && (word_a == 3'h0);
    st_nxt.mark_oe = cs_act;
    st_nxt.busy    = bus.busy;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r         <= '0;
      st_r.s1      <= `ADCSR_PIN_RST;
      st_r.s2      <= `ADCSR_PIN_RST;
      st_r.s3      <= `ADCSR_PIN_RST;
      st_r.stab    <= `ADCSR_PIN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign serial_out_first        = st_r.dout_a;
  assign serial_out_first_oe     = st_r.oe_a;
  assign serial_out_second       = st_r.dout_b;
  assign serial_out_second_oe    = st_r.oe_b;
  assign first_channel_marker    = st_r.mark;
  assign first_channel_marker_oe = st_r.mark_oe;
  assign busy                    = st_r.busy;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  marker_hiz_a: assert property (st_r.stab[`ADCSR_P_CS] |-> !first_channel_marker_oe)
    else $error("marker driven while deselected");
  dout_hiz_a: assert property (st_r.stab[`ADCSR_P_CS] |->
      !serial_out_first_oe && !serial_out_second_oe)
    else $error("data line driven while deselected");
  serial_sel_a: assert property (serial_out_first_oe |->
      st_r.stab[`ADCSR_P_IFS] && !st_r.stab[`ADCSR_P_BYS])
    else $error("serial output outside serial mode");
  marker_word_a: assert property (first_channel_marker |-> st_r.bit_cnt < 7'h10)
    else $error("marker high beyond first word");
  marker_end_a: assert property (st_r.bit_cnt == 7'h10 && first_channel_marker_oe |->
      !first_channel_marker)
    else $error("marker not low after sixteen clocks");
  bit_step_a: assert property ($changed(st_r.bit_cnt) && st_r.bit_cnt != 7'h00 |->
      st_r.bit_cnt == 7'($past(st_r.bit_cnt) + 7'h01))
    else $error("bit counter skipped");
  first_order_a: assert property (serial_out_first_oe && $stable(bus.res) |->
      serial_out_first == bus.res[st_r.bit_cnt[6:4]][~st_r.bit_cnt[3:0]])
    else $error("first line order wrong");
  second_order_a: assert property (serial_out_second_oe && $stable(bus.res) |->
      serial_out_second == bus.res[3'(st_r.bit_cnt[6:4] + 3'h4)][~st_r.bit_cnt[3:0]])
    else $error("second line order wrong");
  load_restart_a: assert property (bus.load |=> st_r.bit_cnt == 7'h00)
    else $error("readout not restarted on new results");
  busy_pin_a: assert property ($rose(bus.busy) |=> busy ##1 busy)
    else $error("busy pin does not follow conversion");

  cov_full_c:   cover property (st_r.bit_cnt == 7'h7f ##[1:40] st_r.bit_cnt == 7'h00);
  cov_frame_c:  cover property ($rose(st_r.stab[`ADCSR_P_CS]) && st_r.bit_cnt == 7'h10);
  cov_rd_busy_c: cover property (serial_out_first_oe && busy);

endmodule : adcsr_top

// ===== shared/adcsr_cfg.svh
`ifndef ADCSR_CFG_SVH
`define ADCSR_CFG_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define ADCSR_WORD_BITS 16
`define ADCSR_NUM_CH    8
`define ADCSR_ACC_BITS  22

// ----------------------------------------
// Timing
// ----------------------------------------
`define ADCSR_CLK_MHZ     50
`define ADCSR_T_SAMPLE_NS 2000
`define ADCSR_CONV_CYC    ((`ADCSR_T_SAMPLE_NS * `ADCSR_CLK_MHZ) / 1000)

// ----------------------------------------
// Pin vector positions and reset
// ----------------------------------------
`define ADCSR_P_CS   0
`define ADCSR_P_SCLK 1
`define ADCSR_P_STA  2
`define ADCSR_P_STB  3
`define ADCSR_P_IFS  4
`define ADCSR_P_BYS  5
`define ADCSR_P_OS   6
`define ADCSR_PIN_RST 9'h003
`define ADCSR_OSR_MAX 3'h6

`endif

// ===== shared/adcsr_if.sv
`timescale 1ns/1ps

interface adcsr_if;
  import adcsr_pkg::*;
  logic             start_a;
  logic             start_b;
  logic [2:0]       os_sel;
  logic             busy;
  logic             load;
  adcsr_res_t       res;
  modport conv (input start_a, input start_b, input os_sel, output busy, output load, output res);
  modport ser  (output start_a, output start_b, output os_sel, input busy, input load, input res);
endinterface : adcsr_if

// ===== shared/adcsr_pkg.sv
`include "adcsr_cfg.svh"

package adcsr_pkg;

  typedef logic [`ADCSR_NUM_CH-1:0][`ADCSR_WORD_BITS-1:0] adcsr_res_t;
  typedef logic [`ADCSR_NUM_CH-1:0][`ADCSR_ACC_BITS-1:0]  adcsr_acc_t;

  typedef struct packed {
    logic       busy;
    logic       load;
    logic       sta_d;
    logic       stb_d;
    logic       arm_a;
    logic       arm_b;
    logic [2:0] oversample_ratio;
    logic [7:0] step;
    logic [6:0] samp;
    adcsr_acc_t acc;
    adcsr_res_t res;
  } adcsr_conv_st_t;

  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
    logic [8:0] s3;
    logic [8:0] stab;
    logic [6:0] bit_cnt;
    logic       dout_a;
    logic       oe_a;
    logic       dout_b;
    logic       oe_b;
    logic       mark;
    logic       mark_oe;
    logic       busy;
  } adcsr_top_st_t;

endpackage : adcsr_pkg

// ===== sim/adcsr_host.sv
`timescale 1ns/1ps

// ----------------------------------------
// Host side of the serial link
// ----------------------------------------
module adcsr_host (
  output logic      cs_n_pin,
  output logic      sclk_pin,
  input  wire logic sa,
  input  wire logic sb,
  input  wire logic mk,
  input  wire logic oea,
  input  wire logic oeb,
  input  wire logic oem
);
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b1;
  end

  // Select edge, clock idles high between frames
  task sel(input logic v);
    #37;
    cs_n_pin = v;
    #200;
  endtask : sel

  // One word: sixteen falls, each bit taken as its fall comes
  task word(output logic [15:0] a, output logic [15:0] b, output logic m, output logic oe);
    int i;
    m  = mk;
    oe = 1'b1;
    for (i = 0; i < 16; i++) begin
      a = {a[14:0], sa};
      b = {b[14:0], sb};
      if (mk !== m) m = 1'bx;
      oe = oe & oea & oeb & oem;
      sclk_pin = 1'b0;
      #80;
      sclk_pin = 1'b1;
      #80;
    end
  endtask : word
endmodule : adcsr_host

// ===== sim/tb_adcsr_top.sv
`timescale 1ns/1ps
`include "adcsr_cfg.svh"

module tb_adcsr_top;
  import adcsr_pkg::*;
  logic       ref_clk, rstn, ifs, bys, sta, stb;
  logic [2:0] osp;
  adcsr_res_t din;
  wire        cs_n, sclk, sa, oea, sb, oeb, mk, oem, busy;
  int         errors, n_checks;
  time        t_busy;

  adcsr_top dut (.ref_clk(ref_clk), .rstn(rstn), .cs_n_pin(cs_n), .sclk_pin(sclk),
    .interface_select_pin(ifs), .byte_select_pin(bys), .oversample_ratio_pins(osp),
    .start_group_one(sta), .start_group_two(stb), .adc_core_data(din),
    .serial_out_first(sa), .serial_out_first_oe(oea), .serial_out_second(sb),
    .serial_out_second_oe(oeb), .first_channel_marker(mk), .first_channel_marker_oe(oem),
    .busy(busy));
  adcsr_host host (.cs_n_pin(cs_n), .sclk_pin(sclk), .sa(sa), .sb(sb), .mk(mk),
    .oea(oea), .oeb(oeb), .oem(oem));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Two-digit set number: mean of two sample sets, half the samples each
  function automatic logic [15:0] val(int s, int ch);
    if (s >= 10) return 16'((int'(val(s / 10, ch)) + int'(val(s % 10, ch))) / 2);
    return 16'(s * 16'h1111 + ch * 16'h0203 + 16'h00a5);
  endfunction : val

  task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // New samples at the first fall at least cyc cycles after busy was seen high
  task load(int s, int cyc);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while ($time - t_busy < cyc * 20 && n < 20000);
    for (int ch = 0; ch < 8; ch++) din[ch] = val(s, ch);
    if (n >= 20000) begin
      errors++;
      finish_test();
    end
  endtask : load

  // Start a conversion, optionally with group one alone first
  task conv_start(input bit stag);
    int n;
    @(negedge ref_clk);
    sta = 1'b1;
    if (stag) begin
      repeat (20) @(negedge ref_clk);
      chk(16'(busy), 16'h0, "busy on one start");
    end
    stb = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    t_busy = $time;
    sta = 1'b0;
    stb = 1'b0;
    chk(16'(busy), 16'h1, "busy rise");
    if (n >= 20) finish_test();
  endtask : conv_start

  task conv_wait(input int len);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    chk(16'(($time - t_busy) / 20), 16'(len), "busy width");
    if (n >= 20000) finish_test();
  endtask : conv_wait

  // Read words starting at counter word w0, framed per word or as one frame
  task rd(input int s, input int w0, input int nw, input bit framed, input bit use_b);
    logic [15:0] a, b;
    logic        m, oe;
    if (!framed) host.sel(1'b0);
    for (int w = w0; w < w0 + nw; w++) begin
      if (framed) host.sel(1'b0);
      host.word(a, b, m, oe);
      if (framed) host.sel(1'b1);
      chk(a, val(s, w % 8), "line a");
      if (use_b) chk(b, val(s, (w + 4) % 8), "line b");
      chk(16'(m), 16'(w % 8 == 0), "marker");
      chk(16'(oe), 16'h1, "drive enable");
    end
    if (!framed) host.sel(1'b1);
    chk(16'({oea, oeb, oem}), 16'h0, "released");
  endtask : rd

  initial begin
    rstn = 1'b0;
    ifs  = 1'b1;
    bys  = 1'b0;
    sta  = 1'b0;
    stb  = 1'b0;
    osp  = 3'h5;
    din  = '0;
    t_busy = 0;
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    chk(16'({oea, oeb, oem, busy}), 16'h0, "reset");
    load(1, 0);
    conv_start(1'b1);
    conv_wait(`ADCSR_CONV_CYC);
    $display("test conversion done");
    rd(1, 0, 4, 1'b1, 1'b1);
    rd(1, 4, 4, 1'b0, 1'b1);
    $display("test dual line done");
    load(2, 0);
    osp = 3'h7;
    conv_start(1'b0);
    rd(1, 0, 4, 1'b0, 1'b1);
    chk(16'(busy), 16'h1, "read ends inside busy");
    load(3, 1650);
    conv_wait(`ADCSR_CONV_CYC * 32);
    rd(23, 0, 8, 1'b0, 1'b0);
    $display("test read in busy done");
    conv_start(1'b0);
    osp = 3'h6;
    conv_wait(`ADCSR_CONV_CYC);
    rd(3, 0, 8, 1'b1, 1'b0);
    conv_start(1'b0);
    conv_wait(`ADCSR_CONV_CYC * 64);
    $display("test ratio seven done");
    ifs = 1'b0;
    host.sel(1'b0);
    chk(16'({oea, oeb, oem}), 16'h0, "parallel mode");
    host.sel(1'b1);
    ifs = 1'b1;
    bys = 1'b1;
    host.sel(1'b0);
    chk(16'({oea, oeb, oem}), 16'h0, "byte mode");
    host.sel(1'b1);
    $display("test mode select done");
    finish_test();
  end
endmodule : tb_adcsr_top
